//--- design/lic_pkg.sv
// Purpose: Shared constants and types for the second indicator control block
// Assumes: 50 MHz system clock, 16-bit register port
// Notes:   Blink tables hold period and off time in milliseconds per rate code
package lic_pkg;

   // Timebase
   localparam int CLK_PERIOD_NS  = 20;
   localparam int TICK_NS        = 1000000;
   localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
   localparam int ACT_ON_MS      = 10;
   // One extra tick covers a partial first millisecond
   localparam int ACT_HOLD_TICKS = ACT_ON_MS + 1;

   // Register addresses
   localparam logic [15:0] ADDR_COMMON = 16'h40C1;
   localparam logic [15:0] ADDR_BLINK  = 16'h40C2;
   localparam logic [15:0] ADDR_CTL    = 16'h40C3;
   localparam logic [15:0] ADDR_STATUS = 16'h40C4;

   // Reset values and writable masks
   localparam logic [15:0] CTL_RESET    = 16'h0310;
   localparam logic [15:0] CTL_WMASK    = 16'hFFFE;
   localparam logic [15:0] BLINK_RESET  = 16'hEC75;
   localparam logic [15:0] COMMON_RESET = 16'h0040;
   localparam logic [15:0] COMMON_WMASK = 16'h0240;

   // Field positions
   localparam int COM_REVERSE_BIT = 9;
   localparam int COM_COL_SEL_BIT = 6;
   localparam int RATE_W          = 4;
   localparam int MODES           = 4;

   typedef enum logic [1:0] {
      LIC_FORCE_OFF,
      LIC_FORCE_ON,
      LIC_FORCE_BLINK1,
      LIC_FORCE_BLINK2
   } lic_force_t;

   typedef struct packed {
      logic       force_enable;
      lic_force_t force_state;
      logic       traffic_blink_always;
      logic       full_duplex_on_enable;
      logic       half_duplex_on_enable;
      logic       transmit_blink_enable;
      logic       receive_blink_enable;
      logic       transmit_on_enable;
      logic       receive_on_enable;
      logic       fast_speed_on_enable;
      logic       slow_speed_on_enable;
      logic       collision_blink_enable;
      logic       fast_speed_blink_enable;
      logic       slow_speed_blink_enable;
      logic       reserved;
   } lic_ctl_t;

   typedef struct packed {
      logic link_up;
      logic speed_100;
      logic full_duplex;
      logic tx_act;
      logic rx_act;
      logic collision;
   } lic_link_t;

   // Period per rate code, ms
   localparam logic [13:0] PERIOD_MS [16] = '{
      14'h2710, 14'h24B8, 14'h1F40, 14'h1B58, 14'h1770, 14'h1388, 14'h0FA0, 14'h0BB8,
      14'h07D0, 14'h03E8, 14'h01F4, 14'h0190, 14'h014D, 14'h00A6, 14'h007D, 14'h0064};

   // Off portion per rate code, ms
   localparam logic [13:0] OFF_MS [16] = '{
      14'h0258, 14'h0292, 14'h0280, 14'h0276, 14'h0294, 14'h012C, 14'h0140, 14'h014A,
      14'h0104, 14'h00A0, 14'h00FA, 14'h00C8, 14'h00A6, 14'h0053, 14'h003E, 14'h0032};

endpackage : lic_pkg

//--- design/lic_indicator.sv
// Purpose: Drives the second indicator from link state, traffic and software force
// Assumes: Status inputs come from logic on MCLK_I; indicator is on when LED_O is high
// Notes:   Blink waves for all four modes run from a shared 1 ms tick
//
// Our own choice: the address-and-strobe port.
module lic_indicator #(
   parameter int TICK_CYCLES = lic_pkg::TICK_CYCLES
) (
   input  wire logic              MCLK_I,
   input  wire logic              RSTN_I,
   input  wire logic [15:0]       ADDR_I,
   input  wire logic [15:0]       WDATA_I,
   input  wire logic              WE_I,
   input  wire logic              RE_I,
   output      logic [15:0]       RDATA_O,
   input  wire lic_pkg::lic_link_t LINK_I,
   output      logic              LED_O
);

   // Rate code of one mode from the blink-rate register
   function automatic logic [3:0] rate_code(input logic [15:0] r, input int mode);
      rate_code = r[(lic_pkg::MODES - 1 - mode) * lic_pkg::RATE_W +: lic_pkg::RATE_W];
   endfunction : rate_code

   // Register state
   lic_pkg::lic_ctl_t ctl;
   logic [15:0]       blink_rate;
   logic [15:0]       common;

   // Timebase
   logic [15:0]       tick_cnt;
   logic              tick;

   // Activity hold
   logic [3:0]        hold;
   logic [3:0]        next_hold;

   // Blink waves per mode
   logic [lic_pkg::MODES-1:0] wave;

   // Decoded conditions
   wire               reverse;
   wire               col_sel_fast;
   wire               link_up;
   wire               speed_10;
   wire               half_duplex;
   wire               act_on_event;
   wire               hold_on;
   wire               steady_on;
   wire               traffic;
   wire               traffic_ok;
   wire               traffic_blink;
   wire               col_blink;
   wire               speed_blink;
   wire               blink_on;
   wire               col_wave;
   wire               force_level;
   wire               next_led;
   wire [15:0]        status;
   wire [15:0]        next_rdata;

   // Register port decode
   wire               wr_ctl;
   wire               wr_blink;
   wire               wr_common;

   assign wr_ctl    = WE_I && (ADDR_I == lic_pkg::ADDR_CTL);
   assign wr_blink  = WE_I && (ADDR_I == lic_pkg::ADDR_BLINK);
   assign wr_common = WE_I && (ADDR_I == lic_pkg::ADDR_COMMON);

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         ctl <= lic_pkg::lic_ctl_t'(lic_pkg::CTL_RESET);
      end else if (wr_ctl) begin
         ctl <= lic_pkg::lic_ctl_t'(WDATA_I & lic_pkg::CTL_WMASK);
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         blink_rate <= lic_pkg::BLINK_RESET;
      end else if (wr_blink) begin
         blink_rate <= WDATA_I;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         common <= lic_pkg::COMMON_RESET;
      end else if (wr_common) begin
         common <= WDATA_I & lic_pkg::COMMON_WMASK;
      end
   end

   assign reverse      = common[lic_pkg::COM_REVERSE_BIT];
   assign col_sel_fast = common[lic_pkg::COM_COL_SEL_BIT];

   // Millisecond tick
   assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   // One blink generator per mode
   genvar g;
   generate
      for (g = 0; g < lic_pkg::MODES; g++) begin : gen_mode
         logic [3:0]  code;
         logic [3:0]  code_q;
         logic [13:0] cnt;
         logic [13:0] period;
         logic [13:0] on_len;
         logic        on_part;

         assign code    = rate_code(blink_rate, g);
         // code to period and off time
         assign period  = lic_pkg::PERIOD_MS[code_q];
         assign on_len  = period - lic_pkg::OFF_MS[code_q];
         assign on_part = (cnt < on_len);
         assign wave[g] = on_part ^ reverse;

         always_ff @(posedge MCLK_I) begin
            if (!RSTN_I) begin
               code_q <= '0;
               cnt    <= '0;
            end else if (code != code_q) begin
               code_q <= code;
               cnt    <= '0;
            end else if (tick) begin
               if (cnt >= period - 14'h0001) begin
                  cnt <= '0;
               end else begin
                  cnt <= cnt + 14'h0001;
               end
            end
         end
      end
   endgenerate

   // Link conditions
   assign link_up     = LINK_I.link_up;
   assign speed_10    = !LINK_I.speed_100;
   assign half_duplex = !LINK_I.full_duplex;

   assign act_on_event = link_up &&
                         ((ctl.transmit_on_enable && LINK_I.tx_act) ||
                          (ctl.receive_on_enable && LINK_I.rx_act));

   always_comb begin
      next_hold = hold;
      if (act_on_event) begin
         next_hold = 4'(lic_pkg::ACT_HOLD_TICKS);
      end else if (!link_up) begin
         next_hold = '0;
      end else if (tick && (hold != 4'h0)) begin
         next_hold = hold - 4'h1;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         hold <= '0;
      end else begin
         hold <= next_hold;
      end
   end

   assign hold_on = act_on_event || (hold != 4'h0);

   assign steady_on = link_up &&
                      ((ctl.full_duplex_on_enable && LINK_I.full_duplex) ||
                       (ctl.half_duplex_on_enable && half_duplex) ||
                       (ctl.fast_speed_on_enable && LINK_I.speed_100) ||
                       (ctl.slow_speed_on_enable && speed_10) ||
                       hold_on);

   assign traffic = (ctl.transmit_blink_enable && LINK_I.tx_act) ||
                    (ctl.receive_blink_enable && LINK_I.rx_act);

   assign traffic_ok    = steady_on ||
                          (ctl.traffic_blink_always && ctl.force_state[0]);
   assign traffic_blink = link_up && traffic && traffic_ok;

   assign col_blink   = link_up && ctl.collision_blink_enable && LINK_I.collision;

   assign speed_blink = link_up &&
                        ((ctl.fast_speed_blink_enable && LINK_I.speed_100) ||
                         (ctl.slow_speed_blink_enable && speed_10));

   assign blink_on = traffic_blink || col_blink || speed_blink;
   assign col_wave = col_sel_fast ? wave[2] : wave[1];

   assign force_level = (ctl.force_state == lic_pkg::LIC_FORCE_ON)     ? 1'b1 :
                        (ctl.force_state == lic_pkg::LIC_FORCE_BLINK1) ? wave[1] :
                        (ctl.force_state == lic_pkg::LIC_FORCE_BLINK2) ? wave[2] :
                        1'b0;

   assign next_led = ctl.force_enable ? force_level :
                     (col_blink && !traffic_blink && !speed_blink) ? col_wave :
                     blink_on ? wave[2] :
                     steady_on;

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         LED_O <= 1'b0;
      end else begin
         LED_O <= next_led;
      end
   end

   // Live state for software
   assign status = {11'h000, hold_on, steady_on, blink_on, ctl.force_enable, LED_O};

   // Read mux, unmapped reads zero
   assign next_rdata = !RE_I                          ? 16'h0000 :
                       (ADDR_I == lic_pkg::ADDR_CTL)    ? 16'(ctl) :
                       (ADDR_I == lic_pkg::ADDR_BLINK)  ? blink_rate :
                       (ADDR_I == lic_pkg::ADDR_COMMON) ? common :
                       (ADDR_I == lic_pkg::ADDR_STATUS) ? status :
                       16'h0000;

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         RDATA_O <= 16'h0000;
      end else begin
         RDATA_O <= next_rdata;
      end
   end

endmodule : lic_indicator

//--- verif/lic_indicator_assertions.sv
// Purpose: Port checks for the indicator block
// Assumes: Control register mirrored from port writes
// Notes:   Steady checks only when no blink cause is present
module lic_chk #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic               MCLK_I,
   input wire logic               RSTN_I,
   input wire logic [15:0]        ADDR_I,
   input wire logic [15:0]        WDATA_I,
   input wire logic               WE_I,
   input wire logic               RE_I,
   input wire logic [15:0]        RDATA_O,
   input wire lic_pkg::lic_link_t LINK_I,
   input wire logic               LED_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] ctl;
   logic [15:0] blink;
   wire         spd = LINK_I.speed_100;
   wire         fdx = LINK_I.full_duplex;
   wire         quiet = !ctl[15] && LINK_I.link_up && ctl[2:1] == 2'h0 && LINK_I[2:0] == 3'h0;
   wire         rd_ctl = RE_I && ADDR_I == lic_pkg::ADDR_CTL;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) ctl <= lic_pkg::CTL_RESET;
      else if (WE_I && ADDR_I == lic_pkg::ADDR_CTL) ctl <= WDATA_I & lic_pkg::CTL_WMASK;
   end
   // Rate register mirrored from port writes
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) blink <= lic_pkg::BLINK_RESET;
      else if (WE_I && ADDR_I == lic_pkg::ADDR_BLINK) blink <= WDATA_I;
   end
   chk_rsvd_zero: assert property (rd_ctl |=> RDATA_O[0] == 1'b0)
      else $error("reserved bit reads one");
   chk_ctl_read: assert property (rd_ctl |=> RDATA_O == $past(ctl))
      else $error("control readback wrong");
   chk_blink_back: assert property (RE_I && ADDR_I == lic_pkg::ADDR_BLINK |=> RDATA_O == $past(blink))
      else $error("blink rate readback wrong");
   chk_force_off: assert property (ctl[15] && ctl[14:13] == 2'h0 |=> !LED_O)
      else $error("forced off but lit");
   chk_force_on: assert property (ctl[15] && ctl[14:13] == 2'h1 |=> LED_O)
      else $error("forced on but dark");
   chk_link_down: assert property (!ctl[15] && !LINK_I.link_up |=> !LED_O)
      else $error("lit with link down");
   chk_speed_on: assert property (quiet && (ctl[4] && !spd || ctl[5] && spd) |=> LED_O)
      else $error("speed steady not lit");
   chk_duplex_on: assert property (quiet && (ctl[11] && fdx || ctl[10] && !fdx) |=> LED_O)
      else $error("duplex steady not lit");
endmodule : lic_chk
bind lic_indicator lic_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
   .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .LINK_I(LINK_I), .LED_O(LED_O));

//--- verif/lic_led_model.sv
// Purpose: Indicator lamp on the pin
// Assumes: Lamp lit while the pin is high
// Notes:   Counts level changes for blink checks
module lic_led_model (
   input  wire logic clk_i,
   input  wire logic led_i,
   input  wire logic clr_i,
   output int        edges_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last;
   always_ff @(posedge clk_i) begin
      last    <= led_i;
      edges_o <= clr_i ? 0 : edges_o + int'(last != led_i);
   end
endmodule : lic_led_model

//--- verif/testbench.sv
// Purpose: Self-checking bench for the indicator block
// Assumes: Short tick of 4 clocks per millisecond
// Notes:   Blinking cases judged by lamp level changes
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic               MCLK_I = 1'b0;
   logic               RSTN_I = 1'b0;
   logic [15:0]        ADDR_I = 16'h0000;
   logic [15:0]        WDATA_I = 16'h0000;
   logic               WE_I = 1'b0;
   logic               RE_I = 1'b0;
   logic [15:0]        RDATA_O;
   lic_pkg::lic_link_t LINK_I = '0;
   logic               LED_O;
   logic               clr = 1'b1;
   int                 edges;
   int                 n_errors = 0;
   int                 check_count = 0;
   int                 cycles = 0;
   int                 exp;
   logic [31:0]        lfsr = 32'hB3F708AB;
   logic [15:0]        ctl;
   logic [15:0]        bl [6] = '{16'hC000, 16'hE000, 16'h0004, 16'h0008, 16'h0220, 16'h3200};
   lic_indicator #(.TICK_CYCLES(4)) dut (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .LINK_I(LINK_I), .LED_O(LED_O));
   lic_led_model lamp (.clk_i(MCLK_I), .led_i(LED_O), .clr_i(clr), .edges_o(edges));
   always #10 MCLK_I = ~MCLK_I;
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : next_rand
   // Expected lamp: 0 dark, 1 lit, 2 blinking
   function automatic int exp_led(input logic [15:0] c, input lic_pkg::lic_link_t l);
      int s;
      int b;
      if (c[15]) return c[14] ? 2 : int'(c[13]);
      if (!l.link_up) return 0;
      s = int'(c[4] & !l.speed_100 | c[5] & l.speed_100 | c[11] & l.full_duplex | c[10] & !l.full_duplex);
      b = int'(c[3] & l.collision | c[2] & l.speed_100 | c[1] & !l.speed_100);
      if ((l.tx_act & c[9] | l.rx_act & c[8]) && (s == 1 || c[13:12] == 2'h3)) b = 1;
      return b == 1 ? 2 : s;
   endfunction : exp_led
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge MCLK_I);
      WE_I <= 1'b1;
      ADDR_I <= a;
      WDATA_I <= d;
      @(posedge MCLK_I);
      WE_I <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
      @(posedge MCLK_I);
      RE_I <= 1'b1;
      ADDR_I <= a;
      @(posedge MCLK_I);
      RE_I <= 1'b0;
      #1;
      cmp(RDATA_O, e);
   endtask : rd_chk
   task automatic close_out();
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   always @(posedge MCLK_I) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         close_out();
      end
   end
   initial begin
      repeat (4) @(posedge MCLK_I);
      RSTN_I <= 1'b1;
      rd_chk(lic_pkg::ADDR_CTL, 16'h0310); // control defaults
      rd_chk(lic_pkg::ADDR_BLINK, 16'hEC75); // rate defaults
      rd_chk(16'h0000, 16'h0000); // unmapped reads zero
      wr(lic_pkg::ADDR_CTL, 16'hFFFF);
      rd_chk(lic_pkg::ADDR_CTL, 16'hFFFE); // reserved bit stays zero
      for (int i = 0; i < 60; i++) begin
         lfsr = next_rand(lfsr);
         ctl = lfsr[15:0] & 16'hFF3E;
         wr(lic_pkg::ADDR_BLINK, lfsr[31:16]);
         rd_chk(lic_pkg::ADDR_BLINK, lfsr[31:16]); // rate fields
         wr(lic_pkg::ADDR_CTL, ctl);
         LINK_I <= lfsr[21:16];
         rd_chk(lic_pkg::ADDR_CTL, ctl); // control fields
         exp = exp_led(ctl, LINK_I);
         if (exp != 2) cmp({15'h0000, LED_O}, exp[15:0]); // output priority
      end
      wr(lic_pkg::ADDR_BLINK, 16'h0FF0);
      LINK_I <= 6'b110101;
      foreach (bl[k]) begin
         wr(lic_pkg::ADDR_CTL, bl[k]);
         clr <= 1'b1;
         @(posedge MCLK_I);
         clr <= 1'b0;
         repeat (900) @(posedge MCLK_I);
         cmp(16'(edges >= 3), 16'h0001); // force, speed, collision and traffic blink
      end
      wr(lic_pkg::ADDR_CTL, 16'h0080);
      LINK_I <= 6'b100000;
      repeat (5) @(posedge MCLK_I);
      LINK_I <= 6'b100100;
      @(posedge MCLK_I);
      LINK_I <= 6'b100000;
      repeat (38) @(posedge MCLK_I);
      #1;
      cmp({15'h0000, LED_O}, 16'h0001); // held after activity
      repeat (30) @(posedge MCLK_I);
      #1;
      cmp({15'h0000, LED_O}, 16'h0000); // dark after hold
      wr(lic_pkg::ADDR_COMMON, 16'hFFFF);
      rd_chk(lic_pkg::ADDR_COMMON, 16'h0240); // reverse and select bits only
      wr(lic_pkg::ADDR_CTL, 16'hE000);
      // Code change restarts the mode 2 wave in its on portion
      wr(lic_pkg::ADDR_BLINK, 16'h0090);
      repeat (4) @(posedge MCLK_I);
      #1;
      cmp({15'h0000, LED_O}, 16'h0000); // reversed start is dark
      wr(lic_pkg::ADDR_COMMON, 16'h0040);
      repeat (2) @(posedge MCLK_I);
      #1;
      cmp({15'h0000, LED_O}, 16'h0001); // restarted wave starts lit
      rd_chk(lic_pkg::ADDR_STATUS, 16'h0003); // force and lamp in status
      close_out();
   end
endmodule : testbench
